// ==== core/codec_ctrl_regs.sv ====
// Control register bank of a USB audio codec: clock, reset, pin and power control.
// Assumes an APB master on clk and asynchronous status levels from the USB processor.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module codec_ctrl_regs #(
	parameter int STABLE = codec_ctrl_pkg::STABLE_CYCLES
) (
	input  wire logic                               clk,
	input  wire logic                               rst,
	input  wire logic [codec_ctrl_pkg::ADDR_W-1:0]  paddr,
	input  wire logic                               psel,
	input  wire logic                               penable,
	input  wire logic                               pwrite,
	input  wire logic [codec_ctrl_pkg::DATA_W-1:0]  pwdata,
	output logic      [codec_ctrl_pkg::DATA_W-1:0]  prdata,
	output logic                                    pready,
	output logic                                    pslverr,
	input  wire logic                               usb_clk_on,
	input  wire logic                               usb_suspend,
	input  wire logic                               usb_irq_n,
	input  wire logic                               micro_powerdown,
	output codec_ctrl_pkg::pll_rate_e               audio_pll_rate,
	output logic      [3:0]                         unit_reset,
	output logic                                    osc48_en,
	output codec_ctrl_pkg::pin_fmt_e                serial_pin_mode,
	output logic                                    gen_io_gpio,
	output logic      [3:0]                         gen_io_oe,
	output logic                                    port3_bit1,
	output logic                                    ext_irq_one_n,
	output logic      [5:0]                         analog_pd
);
	import codec_ctrl_pkg::*;

	typedef struct packed {
		logic [7:0]  rst_pll;
		logic [7:0]  pin_sel;
		logic [7:0]  pwr;
		logic        pready;
		logic        pslverr;
		logic [7:0]  rdata;
		logic        clk_on_prev;
		logic        wake;
		pll_rate_e   pll_rate;
		logic [3:0]  unit_rst;
		logic        osc_en;
		pin_fmt_e    pin_fmt;
		logic        gpio;
		logic [3:0]  gpio_oe;
		logic        p31;
		logic        p33;
		logic [5:0]  pd;
	} regs_s;

	regs_s q;
	regs_s d;

	localparam regs_s RESET_STATE = '{
		rst_pll: RST_PLL_RESET,
		pin_sel: PIN_SEL_RESET,
		pwr: PWR_RESET,
		pready: 1'b0,
		pslverr: 1'b0,
		rdata: 8'h00,
		clk_on_prev: 1'b0,
		wake: 1'b0,
		pll_rate: PLL_44K1,
		unit_rst: 4'h0,
		osc_en: 1'b1,
		pin_fmt: FMT_4PIN,
		gpio: 1'b0,
		gpio_oe: 4'h0,
		p31: 1'b0,
		p33: 1'b1,
		pd: 6'h00
	};

	// Pin levels from the USB processor cross into this clock first.
	logic       clk_on_s;
	logic       susp_s;
	logic       usb_irq_n_s;
	sync2 #(
		.W    (3),
		.INIT (3'h1)
	) u_sync (
		.clk   (clk),
		.rst   (rst),
		.d_in  ({usb_clk_on, usb_suspend, usb_irq_n}),
		.q_out ({clk_on_s, susp_s, usb_irq_n_s})
	);

	restart_if rif ();

	restart_timer #(
		.CYCLES (STABLE)
	) u_timer (
		.clk (clk),
		.rst (rst),
		.rif (rif.timer)
	);

	// Bus decode terms; access completes in the cycle after setup.
	logic setup;
	logic access;
	logic hit_a;
	logic hit_b;
	logic hit_c;
	assign setup  = psel && !penable;
	assign access = psel && penable && q.pready;
	assign hit_a  = reg_hit(paddr, IDX_RST_PLL);
	assign hit_b  = reg_hit(paddr, IDX_PIN_SEL);
	assign hit_c  = reg_hit(paddr, IDX_PWR);

	// A wake-up is the rising edge of the synchronised restart suspend.
	assign rif.kick = clk_on_s && !q.clk_on_prev;

	// Next state of registers, bus answer and registered outputs.
	always_comb begin
		d = q;
		d.pready = setup;
		d.pslverr = setup && !(hit_a || hit_b || hit_c);
		d.clk_on_prev = clk_on_s;
		// Read data is fetched during setup so that it stands from a flop.
		if (setup) begin
			d.rdata = hit_a ? q.rst_pll :
			          hit_b ? q.pin_sel :
			          hit_c ? q.pwr : 8'h00;
		end
		if (access && pwrite) begin
			if (hit_a) begin
				d.rst_pll = pwdata[7:0] & RST_PLL_WMASK;
			end
			if (hit_b) begin
				d.pin_sel = pwdata[7:0];
			end
			if (hit_c) begin
				d.pwr = pwdata[7:0];
			end
		end
		d.pll_rate = pll_map(q.rst_pll[PLL_MSB -: 2]);
		d.unit_rst = q.rst_pll[UNIT_RST_MSB -: 4];
		// oscillator wake
		// The wake latch keeps the oscillator running until the micro leaves
		// power-down; dropping it earlier would stop the clock mid-settle.
		if (rif.kick) begin
			d.wake = 1'b1;
		end else if (!micro_powerdown) begin
			d.wake = 1'b0;
		end
		d.osc_en = !q.pin_sel[OSC_CTRL_BIT] || !micro_powerdown || q.wake;
		d.pin_fmt = fmt_map(q.pin_sel[FMT_MSB -: 2]);
		d.gpio = q.pin_sel[GP_FUNC_BIT];
		d.gpio_oe = {4{q.pin_sel[GP_FUNC_BIT]}} & ~q.pin_sel[GP_DIR_MSB -: 4];
		d.p31 = q.pwr[SUSP_SEL_BIT] ? clk_on_s : susp_s;
		d.p33 = q.pwr[IRQ_SEL_BIT] ? rif.irq_n : usb_irq_n_s;
		d.pd = q.pwr[PD_MSB:0];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= RESET_STATE;
		end else begin
			q <= d;
		end
	end

	// Every output is a flop of the state; upper read bits are always zero.
	assign prdata          = {24'h000000, q.rdata};
	assign pready          = q.pready;
	assign pslverr         = q.pslverr;
	assign audio_pll_rate  = q.pll_rate;
	assign unit_reset      = q.unit_rst;
	assign osc48_en        = q.osc_en;
	assign serial_pin_mode = q.pin_fmt;
	assign gen_io_gpio     = q.gpio;
	assign gen_io_oe       = q.gpio_oe;
	assign port3_bit1      = q.p31;
	assign ext_irq_one_n   = q.p33;
	assign analog_pd       = q.pd;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Writes land in the register at the access edge and in the pins one edge later.
	logic wr_a;
	logic wr_b;
	logic wr_c;
	assign wr_a = access && pwrite && hit_a;
	assign wr_b = access && pwrite && hit_b;
	assign wr_c = access && pwrite && hit_c;

	property p_pll_rate;
		wr_a |-> ##2 (audio_pll_rate == pll_map($past(pwdata[7:6], 2)));
	endproperty
	a_pll_rate: assert property (p_pll_rate) else $error("pll rate wrong");

	property p_unit_rst;
		wr_a |-> ##2 (unit_reset == $past(pwdata[4:1], 2));
	endproperty
	a_unit_rst: assert property (p_unit_rst) else $error("unit reset wrong");

	property p_osc;
		(!q.pin_sel[OSC_CTRL_BIT] || !micro_powerdown) |=> osc48_en;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator off while forced on");

	property p_fmt;
		wr_b |-> ##2 (serial_pin_mode == fmt_map($past(pwdata[6:5], 2)));
	endproperty
	a_fmt: assert property (p_fmt) else $error("pin arrangement wrong");

	property p_gpio;
		wr_b |-> ##2 (gen_io_oe == ({4{$past(pwdata[0], 2)}} & ~$past(pwdata[4:1], 2)));
	endproperty
	a_gpio: assert property (p_gpio) else $error("pin direction wrong");

	property p_susp_route;
		##1 (port3_bit1 == ($past(q.pwr[SUSP_SEL_BIT]) ? $past(clk_on_s) : $past(susp_s)));
	endproperty
	a_susp_route: assert property (p_susp_route) else $error("suspend routing wrong");

	property p_irq_route;
		(q.pwr[IRQ_SEL_BIT] && $fell(rif.irq_n)) |=> !ext_irq_one_n;
	endproperty
	a_irq_route: assert property (p_irq_route) else $error("restart irq not routed");

	property p_pd;
		wr_c |-> ##2 (analog_pd == $past(pwdata[5:0], 2));
	endproperty
	a_pd: assert property (p_pd) else $error("power-down bits wrong");

	property p_wake_osc;
		rif.kick |-> ##2 osc48_en [*3];
	endproperty
	a_wake_osc: assert property (p_wake_osc) else $error("oscillator not re-enabled");

	property p_reserved;
		(setup && hit_a) |=> (prdata[5] == 1'b0 && prdata[0] == 1'b0 && prdata[31:8] == 24'h0);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

	// Routing, read-back and wake holding, each seen one edge after its cause; the pin function is seen two edges after its write.
	property p_gpio_func;
		wr_b |-> ##2 (gen_io_gpio == $past(pwdata[GP_FUNC_BIT], 2));
	endproperty
	a_gpio_func: assert property (p_gpio_func) else $error("pin function wrong");

	property p_usb_irq;
		!q.pwr[IRQ_SEL_BIT] |=> (ext_irq_one_n == $past(usb_irq_n_s));
	endproperty
	a_usb_irq: assert property (p_usb_irq) else $error("usb irq not routed");

	property p_restart_susp;
		q.pwr[SUSP_SEL_BIT] |=> (port3_bit1 == $past(clk_on_s));
	endproperty
	a_restart_susp: assert property (p_restart_susp) else $error("restart suspend not routed");

	property p_irq_rise;
		(q.pwr[IRQ_SEL_BIT] && $rose(rif.irq_n)) |=> ext_irq_one_n;
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("restart irq rise lost");

	property p_wake_hold;
		(q.wake && micro_powerdown) |=> osc48_en;
	endproperty
	a_wake_hold: assert property (p_wake_hold) else $error("oscillator dropped while waking");

	property p_rsvd_write;
		wr_a |=> (q.rst_pll[5] == 1'b0 && q.rst_pll[0] == 1'b0);
	endproperty
	a_rsvd_write: assert property (p_rsvd_write) else $error("reserved bit stored");

	property p_pwr_read;
		(setup && hit_c) |=> (prdata[REG_W-1:0] == $past(q.pwr));
	endproperty
	a_pwr_read: assert property (p_pwr_read) else $error("power register read wrong");

	property p_pin_read;
		(setup && hit_b) |=> (prdata[REG_W-1:0] == $past(q.pin_sel));
	endproperty
	a_pin_read: assert property (p_pin_read) else $error("pin register read wrong");

	c_wr_pwr: cover property (wr_c ##2 analog_pd == 6'h3F);
	c_gpio: cover property (wr_b ##2 gen_io_gpio);
	c_wake: cover property (q.pwr[IRQ_SEL_BIT] && $rose(ext_irq_one_n));
	c_err: cover property (access && pslverr);
endmodule

// ==== core/codec_ctrl_pkg.sv ====
// Constants, types and decode helpers shared by the codec control register bank.
// Assumes a single 50 MHz clock domain and an APB slave with 32-bit data.
package codec_ctrl_pkg;

	// Bus widths.
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;

	// Register indices; the byte address is four times the index.
	localparam logic [13:0] IDX_RST_PLL = 14'h1001;
	localparam logic [13:0] IDX_PIN_SEL = 14'h1002;
	localparam logic [13:0] IDX_PWR     = 14'h1003;

	// Writable bits and reset values.
	localparam logic [7:0] RST_PLL_WMASK = 8'hDE;
	localparam logic [7:0] RST_PLL_RESET = 8'h00;
	localparam logic [7:0] PIN_SEL_RESET = 8'h00;
	localparam logic [7:0] PWR_RESET     = 8'h00;

	// Field positions.
	localparam int PLL_MSB      = 7;
	localparam int UNIT_RST_MSB = 4;
	localparam int OSC_CTRL_BIT = 7;
	localparam int FMT_MSB      = 6;
	localparam int GP_DIR_MSB   = 4;
	localparam int GP_FUNC_BIT  = 0;
	localparam int SUSP_SEL_BIT = 7;
	localparam int IRQ_SEL_BIT  = 6;
	localparam int PD_MSB       = 5;

	// Oscillator settling time after a wake-up, in clock cycles.
	localparam int STABLE_CYCLES = 2048;

	typedef enum logic [1:0] {
		PLL_44K1 = 2'h0,
		PLL_32K  = 2'h1,
		PLL_48K  = 2'h2
	} pll_rate_e;

	typedef enum logic [1:0] {
		FMT_4PIN    = 2'h0,
		FMT_6PIN    = 2'h1,
		FMT_3PIN_IN = 2'h2
	} pin_fmt_e;

	// Both 00 and 11 select the 44.1 kHz family.
	function automatic pll_rate_e pll_map(input logic [1:0] f);
		pll_map = (f == 2'h3) ? PLL_44K1 : pll_rate_e'(f);
	endfunction

	// Both 10 and 11 select the three-pin input-only arrangement.
	function automatic pin_fmt_e fmt_map(input logic [1:0] f);
		fmt_map = f[1] ? FMT_3PIN_IN : pin_fmt_e'(f);
	endfunction

	// Word-aligned address match against a register index.
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [13:0] idx);
		reg_hit = (a == {idx, 2'b00});
	endfunction

endpackage

// ==== core/restart_if.sv ====
// Link between the register bank and the wake-up settling timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface restart_if;
	logic kick;
	logic irq_n;
	modport timer (input kick, output irq_n);
	modport ctrl  (output kick, input irq_n);
endinterface

// ==== core/sync2.sv ====
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; multi-bit words are not kept coherent.
`timescale 1ns/1ps
module sync2 #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sy_s;

	sy_s q;
	sy_s d;

	// The first stage feeds only the second stage.
	always_comb begin
		d.s1 = d_in;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{s1: INIT, s2: INIT};
		end else begin
			q <= d;
		end
	end

	assign q_out = q.s2;
endmodule

// ==== core/restart_timer.sv ====
// Settling timer started by a wake-up: holds the restart interrupt low while counting.
// Assumes kick is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module restart_timer #(
	parameter int CYCLES = codec_ctrl_pkg::STABLE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	restart_if.timer rif
);
	import codec_ctrl_pkg::*;

	localparam int CW = $clog2(CYCLES);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	localparam logic [CW:0] FULL = (CW + 1)'(CYCLES);

	typedef enum logic {
		T_IDLE  = 1'b0,
		T_COUNT = 1'b1
	} tstate_e;

	typedef struct packed {
		tstate_e        st;
		logic [CW-1:0]  cnt;
		logic           irq_n;
	} tmr_s;

	tmr_s q;
	tmr_s d;

	// count then rise
	// A new kick while counting starts the wait over, so the edge always
	// comes a full settling time after the latest wake-up.
	always_comb begin
		d = q;
		unique case (q.st)
			T_IDLE: begin
				if (rif.kick) begin
					d.st = T_COUNT;
					d.cnt = '0;
					d.irq_n = 1'b0;
				end
			end
			T_COUNT: begin
				if (rif.kick) begin
					d.cnt = '0;
				end else if (q.cnt == LAST) begin
					d.st = T_IDLE;
					d.irq_n = 1'b1;
				end else begin
					d.cnt = q.cnt + 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '{st: T_IDLE, cnt: '0, irq_n: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign rif.irq_n = q.irq_n;

	// Length of the current low phase, for checking only.
	logic [CW:0] lo_len;
	always_ff @(posedge clk) begin
		if (rst || rif.kick || q.irq_n) begin
			lo_len <= '0;
		end else begin
			lo_len <= lo_len + 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_kick_low;
		rif.kick |=> !q.irq_n;
	endproperty
	a_kick_low: assert property (p_kick_low) else $error("kick did not drop irq");

	property p_rise_time;
		$rose(q.irq_n) |-> ($past(lo_len) == FULL - 1'b1);
	endproperty
	a_rise_time: assert property (p_rise_time) else $error("irq rose early or late");

	c_done: cover property ($rose(q.irq_n));
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the codec control register bank, driven over APB.
// Assumes a 50 MHz clock, synchronous active-high reset and a short settling count.
`timescale 1ns/1ps
module testbench;
	import codec_ctrl_pkg::*;

	localparam int STB = 8;
	localparam logic [15:0] A_RST = {IDX_RST_PLL, 2'b00};
	localparam logic [15:0] A_PIN = {IDX_PIN_SEL, 2'b00};
	localparam logic [15:0] A_PWR = {IDX_PWR, 2'b00};

	logic              clk;
	logic              rst;
	logic [ADDR_W-1:0] paddr;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	logic              usb_clk_on;
	logic              usb_suspend;
	logic              usb_irq_n;
	logic              micro_powerdown;
	pll_rate_e         audio_pll_rate;
	logic [3:0]        unit_reset;
	logic              osc48_en;
	pin_fmt_e          serial_pin_mode;
	logic              gen_io_gpio;
	logic [3:0]        gen_io_oe;
	logic              port3_bit1;
	logic              ext_irq_one_n;
	logic [5:0]        analog_pd;
	int                n_mismatch;
	int                n_tests;
	logic [31:0]       rdat;
	logic              rerr;
	int                cnt;

	// The short settling count keeps the wake-up scenario brief.
	codec_ctrl_regs #(.STABLE(STB)) u_codec_ctrl_regs (
		.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .usb_clk_on(usb_clk_on), .usb_suspend(usb_suspend),
		.usb_irq_n(usb_irq_n), .micro_powerdown(micro_powerdown),
		.audio_pll_rate(audio_pll_rate), .unit_reset(unit_reset), .osc48_en(osc48_en),
		.serial_pin_mode(serial_pin_mode), .gen_io_gpio(gen_io_gpio),
		.gen_io_oe(gen_io_oe), .port3_bit1(port3_bit1),
		.ext_irq_one_n(ext_irq_one_n), .analog_pd(analog_pd)
	);

	// Free-running bench clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("totals: mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the answer is taken at the rising edge that sees pready high,
	// and only then is the request released.
	task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
		int  i;
		logic done;
		done = 1'b0;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 16 && !done; i++) begin
			@(posedge clk);
			if (pready === 1'b1) begin
				done = 1'b1;
				rdat = prdata;
				rerr = pslverr;
			end
		end
		if (!done) begin
			n_mismatch++;
			complete_run();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Lets n edges pass, then stops mid-cycle where outputs are settled.
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	initial begin
		n_mismatch = 0;
		n_tests = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		usb_clk_on = 1'b0;
		usb_suspend = 1'b0;
		usb_irq_n = 1'b1;
		micro_powerdown = 1'b0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		settle(1);
		check(osc48_en, 1);
		check(ext_irq_one_n, 1);
		for (int f = 0; f < 4; f++) begin
			apb(1'b1, A_RST, f << 6);
			settle(2);
			check(audio_pll_rate, (f == 3) ? 0 : f);
		end
		apb(1'b1, A_RST, 32'h000000FF);
		apb(1'b0, A_RST, 32'h0);
		check(rdat, 32'h000000DE);
		check(unit_reset, 4'hF);
		apb(1'b1, A_RST, 32'h00000033);
		apb(1'b0, A_RST, 32'h0);
		check(rdat, 32'h00000012);
		check(unit_reset, 4'h9);
		// Unmapped place is refused and leaves the bank alone.
		apb(1'b1, 16'h4010, 32'h000000FF);
		check(rerr, 1);
		apb(1'b0, 16'h4010, 32'h0);
		check(rerr, 1);
		check(rdat, 32'h00000000);
		apb(1'b0, A_RST, 32'h0);
		check(rdat, 32'h00000012);
		for (int f = 0; f < 4; f++) begin
			apb(1'b1, A_PIN, f << 5);
			settle(2);
			check(serial_pin_mode, (f > 1) ? 2 : f);
		end
		apb(1'b1, A_PIN, 32'h0000000B);
		settle(2);
		check({gen_io_gpio, gen_io_oe}, 5'h1A);
		apb(1'b1, A_PIN, 32'h0000000A);
		settle(2);
		check({gen_io_gpio, gen_io_oe}, 5'h00);
		apb(1'b0, A_PIN, 32'h0);
		check(rdat, 32'h0000000A);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, A_PWR, 1 << i);
			apb(1'b0, A_PWR, 32'h0);
			check(rdat, 1 << i);
			check(analog_pd, 1 << i);
		end
		apb(1'b1, A_PWR, 32'h0);
		@(posedge clk);
		usb_suspend <= 1'b1;
		usb_irq_n <= 1'b0;
		settle(5);
		check({port3_bit1, ext_irq_one_n}, 2'b10);
		@(posedge clk);
		usb_suspend <= 1'b0;
		usb_irq_n <= 1'b1;
		settle(5);
		check({port3_bit1, ext_irq_one_n}, 2'b01);
		@(posedge clk);
		micro_powerdown <= 1'b1;
		apb(1'b1, A_PIN, 32'h00000080);
		settle(2);
		check(osc48_en, 0);
		apb(1'b1, A_PIN, 32'h00000000);
		settle(2);
		check(osc48_en, 1);
		apb(1'b1, A_PIN, 32'h00000080);
		settle(2);
		check(osc48_en, 0);
		apb(1'b1, A_PWR, 32'h000000FF);
		@(posedge clk);
		usb_suspend <= 1'b1;
		settle(5);
		check({port3_bit1, ext_irq_one_n}, 2'b01);
		@(posedge clk);
		usb_clk_on <= 1'b1;
		cnt = 0;
		while (ext_irq_one_n !== 1'b0 && cnt < 20) begin
			settle(0);
			cnt++;
		end
		if (cnt >= 20) begin
			n_mismatch++;
			complete_run();
		end
		check(ext_irq_one_n, 0);
		check({osc48_en, port3_bit1}, 2'b11);
		cnt = 0;
		while (ext_irq_one_n === 1'b0 && cnt < 100) begin
			settle(0);
			cnt++;
		end
		if (cnt >= 100) begin
			n_mismatch++;
			complete_run();
		end
		// The routed interrupt stays low for exactly the settling count.
		check(cnt, STB);
		check(ext_irq_one_n, 1);
		@(posedge clk);
		micro_powerdown <= 1'b0;
		settle(2);
		check(osc48_en, 1);
		complete_run();
	end
endmodule
